/* File: logic/sac_defines.svh */
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Three-byte read returns result in bytes two and three, zero padded.
// - Unipolar results are straight binary, bipolar results two's complement.
// - Serial output changes only on falling clock edges, MSB first.
// - Clock-mode bit picks serial clock or internal pacing; shifting always SCLK.
// - Control byte bit 0 is clock mode: one external, zero internal.
// - External mode: strobe high two clock periods after last control bit.
// - External mode: one decision per falling edge, shown on eight falls.
// - After the eight result bits, every further clock shifts out zero.
// - External mode: outputs float with select high; strobe low after fall.
// - Internal mode: strobe low at conversion start, high when done.
// - Internal mode: result held in register, readable any later time.
// - Internal mode: MSB appears on second falling edge after strobe rises.
// - Internal mode: select high blocks input, floats output, conversion runs.
// - Start bit is first high bit while idle or after MSB shown.
// - One input bit per rising edge with select low; leading zeros ignored.
// - Conversion starts on falling edge after the eighth control bit.
// - Select toggle before completion aborts; next high bit starts anew.
// - Back-to-back conversions every 10 clocks, or 16 for byte hosts.
// - Reset gives internal mode, strobe high, zeros out, start accepted.
// - Control byte bit 1 is power mode: one on, zero software power-down.
// - Software power-down finishes current conversion first; result readable.
// - Start bit wakes device; power bit zero sleeps again after one conversion.
// - Shutdown pin low halts conversion at once and powers down.
// - Shutdown pin high enabled, floating enabled with reference, low down.
//////////////////////////////////////////////////////////////////////////////
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH

// Control byte field positions.
`define SAC_CLOCK_MODE_BIT 0
`define SAC_POWER_MODE_BIT 1
`define SAC_SINGLE_ENDED_BIT 2
`define SAC_POLARITY_SELECT_BIT 3
`define SAC_CHAN_SEL_LSB 4
`define SAC_CHAN_SEL_MSB 6
`define SAC_CTRL_BITS 8
`define SAC_RES_BITS 8

// Reset values.
`define SAC_RST_EXT_MODE 1'h0
`define SAC_RST_STROBE 1'h1

// Timing.
`define SAC_MCLK_HZ 25000000
`define SAC_INT_CONV_NS 25000
`define SAC_INT_CONV_CYC \
   ((`SAC_INT_CONV_NS * (`SAC_MCLK_HZ / 1000000)) / 1000)
`define SAC_INT_STEP_CYC (`SAC_INT_CONV_CYC / (`SAC_RES_BITS + 1))
`define SAC_INT_DIV_W 7
`define SAC_EXT_STROBE_FALLS 2

`endif

/* File: logic/sac_pkg.sv */
`include "sac_defines.svh"

package sac_pkg;

   // Conversion sequencer states.
   typedef enum logic [1:0] {
      ST_IDLE     = 2'b00,
      ST_EXT_STB  = 2'b01,
      ST_EXT_CONV = 2'b10,
      ST_INT_CONV = 2'b11
   } sac_state_t;

   // Whole state of the control module.
   typedef struct packed {
      logic cs_s1, cs_s2, cs_prev;
      logic sck_s1, sck_s2, sck_prev;
      logic din_s1, din_s2;
      logic lvl_s1, lvl_s2, flt_s1, flt_s2;
      logic cmp_s1, cmp_s2;
      sac_state_t state;
      logic rx_act;
      logic [3:0] bit_cnt;
      logic [`SAC_CTRL_BITS-1:0] ctrl;
      logic ext_mode, pwr_on, soft_pd, uni, sgl;
      logic [2:0] sel;
      logic [3:0] fall_cnt;
      logic [`SAC_RES_BITS:0] out_sr;
      logic msb_shown;
      logic [`SAC_INT_DIV_W-1:0] int_div;
      logic [3:0] int_phase;
      logic sar_start, sar_abort, sar_step;
      logic [`SAC_RES_BITS-1:0] dac;
      logic hold, dout, dout_oe, strobe, strobe_oe, pd, ref_en;
   } sac_ctl_st_t;

endpackage

/* File: logic/sac_sar_if.sv */
`timescale 1ns/10ps

// Link between the control sequencer and the approximation register.
interface sac_sar_if #(parameter int RES_BITS = 8);
   logic start;
   logic abort;
   logic step;
   logic comp;
   logic busy;
   logic done;
   logic [RES_BITS-1:0] trial;
   logic [RES_BITS-1:0] result;

   modport ctrl (output start, abort, step, comp,
                 input busy, done, trial, result);
   modport engine (input start, abort, step, comp,
                   output busy, done, trial, result);
endinterface

/* File: logic/sac_sar_engine.sv */
`timescale 1ns/10ps

// Successive-approximation register: one decision per step, MSB first.
module sac_sar_engine #(
   parameter int RES_BITS = 8
) (
   input wire logic MCLK,
   input wire logic NRST,
   sac_sar_if.engine sar
);

   localparam int IW = $clog2(RES_BITS);

   typedef struct packed {
      logic [RES_BITS-1:0] trial;
      logic [RES_BITS-1:0] result;
      logic [IW-1:0] idx;
      logic busy;
      logic done;
   } sac_sar_st_t;

   sac_sar_st_t q;
   sac_sar_st_t d;

   // Next state: start loads mid-scale, each step keeps or drops one bit.
   always_comb begin
      d = q;
      d.done = 1'b0;
      if (sar.start) begin
         d.trial = '0;
         d.trial[RES_BITS-1] = 1'b1;
         d.result = '0;
         d.idx = IW'(RES_BITS - 1);
         d.busy = 1'b1;
      end else if (sar.abort) begin
         d.busy = 1'b0;
      end else if (sar.step && q.busy) begin
         d.result[q.idx] = sar.comp;
         d.trial[q.idx] = sar.comp;
         if (q.idx == '0) begin
            d.busy = 1'b0;
            d.done = 1'b1;
         end else begin
            d.trial[q.idx - IW'(1)] = 1'b1;
            d.idx = q.idx - IW'(1);
         end
      end
      if (!NRST) begin
         d = '0;
      end
   end

   // State register.
   always_ff @(posedge MCLK) begin
      q <= d;
   end

   assign sar.busy = q.busy;
   assign sar.done = q.done;
   assign sar.trial = q.trial;
   assign sar.result = q.result;

endmodule // sac_sar_engine

/* File: logic/sac_ctrl.sv */
`timescale 1ns/10ps
`include "sac_defines.svh"

// Serial converter control: framing, sequencing, output shifting, power.
module sac_ctrl #(
   parameter int INT_STEP_CYC = `SAC_INT_STEP_CYC
) (
   input wire logic MCLK,
   input wire logic NRST,
   input wire logic CS_N,
   input wire logic SCLK,
   input wire logic DIN,
   input wire logic SHUTDOWN_PIN_LEVEL,
   input wire logic SHUTDOWN_PIN_FLOAT,
   input wire logic COMP_IN,
   output logic DOUT,
   output logic DOUT_OE,
   output logic CONVERSION_STROBE,
   output logic CONVERSION_STROBE_OE,
   output logic [`SAC_RES_BITS-1:0] DAC_CODE,
   output logic TRACK_HOLD,
   output logic [2:0] CHAN_SEL,
   output logic SINGLE_ENDED,
   output logic UNIPOLAR,
   output logic POWER_DOWN,
   output logic REF_ENABLE
);

   //////////////////////////////////////////////////////////////////////////
   // Helpers and instances
   //////////////////////////////////////////////////////////////////////////

   // Unipolar keeps straight binary; bipolar flips the MSB.
   function automatic logic [`SAC_RES_BITS-1:0] fmt_result(
      input logic [`SAC_RES_BITS-1:0] raw,
      input logic uni
   );
      fmt_result = raw;
      fmt_result[`SAC_RES_BITS-1] = raw[`SAC_RES_BITS-1] ^ ~uni;
   endfunction

   sac_pkg::sac_ctl_st_t q;
   sac_pkg::sac_ctl_st_t d;

   sac_sar_if #(.RES_BITS(`SAC_RES_BITS)) sar ();

   sac_sar_engine #(.RES_BITS(`SAC_RES_BITS)) u_sar (
      .MCLK(MCLK),
      .NRST(NRST),
      .sar(sar.engine)
   );

   // Control requests to the approximation register come from flops.
   assign sar.start = q.sar_start;
   assign sar.abort = q.sar_abort;
   assign sar.step = q.sar_step;
   assign sar.comp = q.cmp_s2;

   //////////////////////////////////////////////////////////////////////////
   // Decoded events from the synchronised pins
   //////////////////////////////////////////////////////////////////////////

   logic sck_rise;
   logic sck_fall;
   logic cs_fall;
   logic hard_sd;
   logic start_ok;
   logic ctrl_full;
   logic ext_step;
   logic int_tick;

   // Edges are taken between the second stage and its delayed copy.
   always_comb begin
      sck_rise = q.sck_s2 & ~q.sck_prev;
      sck_fall = ~q.sck_s2 & q.sck_prev;
      cs_fall = ~q.cs_s2 & q.cs_prev;
      hard_sd = ~q.lvl_s2 & ~q.flt_s2;
      start_ok = (q.state == sac_pkg::ST_IDLE) | q.msb_shown;
      ctrl_full = q.rx_act & (q.bit_cnt == 4'(`SAC_CTRL_BITS));
      ext_step = ((q.state == sac_pkg::ST_EXT_STB) &&
                  (q.fall_cnt == 4'(`SAC_EXT_STROBE_FALLS - 1))) ||
                 (q.state == sac_pkg::ST_EXT_CONV);
      int_tick = (q.state == sac_pkg::ST_INT_CONV) &&
                 (q.int_div == `SAC_INT_DIV_W'(INT_STEP_CYC - 1));
   end

   //////////////////////////////////////////////////////////////////////////
   // Next-state logic
   //////////////////////////////////////////////////////////////////////////

   // One process computes the whole next state of the block.
   always_comb begin
      d = q;

      // Two-stage synchronisers on every pin and the comparator.
      d.cs_s1 = CS_N;
      d.cs_s2 = q.cs_s1;
      d.cs_prev = q.cs_s2;
      d.sck_s1 = SCLK;
      d.sck_s2 = q.sck_s1;
      d.sck_prev = q.sck_s2;
      d.din_s1 = DIN;
      d.din_s2 = q.din_s1;
      d.lvl_s1 = SHUTDOWN_PIN_LEVEL;
      d.lvl_s2 = q.lvl_s1;
      d.flt_s1 = SHUTDOWN_PIN_FLOAT;
      d.flt_s2 = q.flt_s1;
      d.cmp_s1 = COMP_IN;
      d.cmp_s2 = q.cmp_s1;

      // Request pulses last one cycle.
      d.sar_start = 1'b0;
      d.sar_abort = 1'b0;
      d.sar_step = 1'b0;

      // Analog-side copies of the approximation register.
      d.dac = sar.trial;
      d.hold = sar.busy;

      // Output enables follow select; internal mode keeps the strobe on.
      d.dout_oe = ~q.cs_s2;
      d.strobe_oe = ~q.ext_mode | ~q.cs_s2;
      d.ref_en = q.flt_s2 & ~hard_sd;

      // Internal pacing: a sample slot, then one decision per tick.
      if (q.state == sac_pkg::ST_INT_CONV) begin
         if (int_tick) begin
            d.int_div = '0;
            d.int_phase = q.int_phase + 4'h1;
            d.sar_step = (q.int_phase != 4'h0);
         end else begin
            d.int_div = q.int_div + `SAC_INT_DIV_W'(1);
         end
      end

      // Internal conversion done: strobe up, result held for reading.
      if (sar.done && (q.state == sac_pkg::ST_INT_CONV)) begin
         d.state = sac_pkg::ST_IDLE;
         d.strobe = 1'b1;
         d.out_sr = {1'b0, fmt_result(sar.result, q.uni)};
         d.soft_pd = ~q.pwr_on;
      end

      // A select toggle cancels a frame and any unfinished conversion.
      if (cs_fall) begin
         d.rx_act = 1'b0;
         if (q.ext_mode) begin
            d.strobe = 1'b0;
         end
         if (q.state != sac_pkg::ST_IDLE) begin
            d.sar_abort = 1'b1;
            d.state = sac_pkg::ST_IDLE;
            d.strobe = ~q.ext_mode;
         end
      end

      // Input capture on rising edges while selected.
      if (sck_rise && !q.cs_s2 && !hard_sd) begin
         if (q.rx_act) begin
            if (!ctrl_full) begin
               d.ctrl = {q.ctrl[`SAC_CTRL_BITS-2:0], q.din_s2};
               d.bit_cnt = q.bit_cnt + 4'h1;
            end
         end else if (q.din_s2 && start_ok) begin
            d.rx_act = 1'b1;
            d.ctrl = `SAC_CTRL_BITS'(1);
            d.bit_cnt = 4'h1;
            d.soft_pd = 1'b0;
         end
      end

      // Falling edges: start, decide, or shift held data.
      if (sck_fall) begin
         if (ctrl_full) begin
            d.rx_act = 1'b0;
            d.ext_mode = q.ctrl[`SAC_CLOCK_MODE_BIT];
            d.pwr_on = q.ctrl[`SAC_POWER_MODE_BIT];
            d.sgl = q.ctrl[`SAC_SINGLE_ENDED_BIT];
            d.uni = q.ctrl[`SAC_POLARITY_SELECT_BIT];
            d.sel = q.ctrl[`SAC_CHAN_SEL_MSB:`SAC_CHAN_SEL_LSB];
            d.sar_start = 1'b1;
            d.msb_shown = 1'b0;
            d.fall_cnt = 4'h0;
            d.out_sr = '0;
            d.dout = 1'b0;
            if (q.ctrl[`SAC_CLOCK_MODE_BIT]) begin
               d.state = sac_pkg::ST_EXT_STB;
               d.strobe = 1'b1;
            end else begin
               d.state = sac_pkg::ST_INT_CONV;
               d.strobe = 1'b0;
               d.int_div = '0;
               d.int_phase = 4'h0;
            end
         end else if (ext_step) begin
            // Each decision goes straight to the output, MSB first.
            d.sar_step = 1'b1;
            d.strobe = 1'b0;
            d.msb_shown = 1'b1;
            d.state = sac_pkg::ST_EXT_CONV;
            if (q.state == sac_pkg::ST_EXT_STB) begin
               d.dout = q.cmp_s2 ^ ~q.uni;
               d.fall_cnt = 4'h1;
            end else begin
               d.dout = q.cmp_s2;
               d.fall_cnt = q.fall_cnt + 4'h1;
               if (q.fall_cnt == 4'(`SAC_RES_BITS - 1)) begin
                  d.state = sac_pkg::ST_IDLE;
                  d.soft_pd = ~q.pwr_on;
               end
            end
         end else begin
            // Strobe hold, held result or trailing zeros.
            if (q.state == sac_pkg::ST_EXT_STB) begin
               d.fall_cnt = q.fall_cnt + 4'h1;
            end
            d.dout = q.out_sr[`SAC_RES_BITS];
            d.out_sr = {q.out_sr[`SAC_RES_BITS-1:0], 1'b0};
            if (q.out_sr[`SAC_RES_BITS-1] ||
                q.out_sr[`SAC_RES_BITS] == 1'b0) begin
               d.msb_shown = q.msb_shown;
            end
         end
      end

      // Hard shutdown stops reception and conversion at once and wins over power bit.
      if (hard_sd) begin
         d.rx_act = 1'b0;
         if (q.state != sac_pkg::ST_IDLE) begin
            d.sar_abort = 1'b1;
            d.state = sac_pkg::ST_IDLE;
         end
      end

      // Combined power-down indication.
      d.pd = d.soft_pd | hard_sd;

      // Synchronous reset: internal mode, strobe high, zeros out.
      if (!NRST) begin
         d = '0;
         d.cs_s1 = 1'b1;
         d.cs_s2 = 1'b1;
         d.cs_prev = 1'b1;
         d.pwr_on = 1'b1;
         d.ext_mode = `SAC_RST_EXT_MODE;
         d.strobe = `SAC_RST_STROBE;
         d.strobe_oe = 1'b1;
         d.uni = 1'b1;
         d.state = sac_pkg::ST_IDLE;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // State register and outputs
   //////////////////////////////////////////////////////////////////////////

   // The only clocked process of the block.
   always_ff @(posedge MCLK) begin
      q <= d;
   end

   // All outputs are fields of the state register.
   assign DOUT = q.dout;
   assign DOUT_OE = q.dout_oe;
   assign CONVERSION_STROBE = q.strobe;
   assign CONVERSION_STROBE_OE = q.strobe_oe;
   assign DAC_CODE = q.dac;
   assign TRACK_HOLD = q.hold;
   assign CHAN_SEL = q.sel;
   assign SINGLE_ENDED = q.sgl;
   assign UNIPOLAR = q.uni;
   assign POWER_DOWN = q.pd;
   assign REF_ENABLE = q.ref_en;

endmodule // sac_ctrl

/* File: bench/sac_ctrl_properties.sv */
`timescale 1ns/10ps

// Watches the converter pins and flags timing or state slips.
module sac_ctrl_properties (
   input wire logic MCLK,
   input wire logic NRST,
   input wire logic CS_N,
   input wire logic SCLK,
   input wire logic SHUTDOWN_PIN_LEVEL,
   input wire logic SHUTDOWN_PIN_FLOAT,
   input wire logic DOUT,
   input wire logic DOUT_OE,
   input wire logic CONVERSION_STROBE,
   input wire logic CONVERSION_STROBE_OE,
   input wire logic TRACK_HOLD,
   input wire logic POWER_DOWN,
   input wire logic REF_ENABLE
);
   // All checks share the system clock and its reset.
   default clocking @(posedge MCLK);
   endclocking
   default disable iff (!NRST);

   ////////////////////////////////////////////////////////////////////////////
   // Pin drive follows the select pin after resynchronisation.
   chk_dout_float:
   assert property (CS_N [*5] |-> !DOUT_OE)
      else $error("data output driven with select high");
   chk_strobe_driven:
   assert property ((!CS_N && (SHUTDOWN_PIN_LEVEL || SHUTDOWN_PIN_FLOAT))
      [*5] |-> CONVERSION_STROBE_OE)
      else $error("strobe not driven with select low");
   // Data output and strobe move only while the serial clock is low, never while it is high.
   chk_dout_on_fall:
   assert property ($changed(DOUT) |-> !$past(SCLK) && !$past(SCLK, 2))
      else $error("data output changed during clock high");
   chk_strobe_on_fall:
   assert property ($changed(CONVERSION_STROBE) |->
      !$past(SCLK) && !$past(SCLK, 2))
      else $error("strobe changed during clock high");
   // A strobe raised by a clock fall lasts exactly two clock periods.
   chk_strobe_pulse:
   assert property ($rose(CONVERSION_STROBE) && $past(SCLK, 6) |->
      CONVERSION_STROBE [*8] ##1 CONVERSION_STROBE [*8] ##1
      !CONVERSION_STROBE)
      else $error("external strobe pulse length wrong");
   // Shutdown pin low halts conversion and powers down.
   chk_shutdown_halt:
   // Abort travels sync, request flop, engine and hold flop: five cycles.
   assert property ((!SHUTDOWN_PIN_LEVEL && !SHUTDOWN_PIN_FLOAT) [*6] |->
      POWER_DOWN && !TRACK_HOLD)
      else $error("shutdown pin did not halt the converter");
   chk_ref_follow:
   assert property ($stable(SHUTDOWN_PIN_FLOAT) [*5] |->
      REF_ENABLE == SHUTDOWN_PIN_FLOAT)
      else $error("reference enable does not follow pin state");
   chk_pd_no_hold:
   // The last decision step lands one cycle after power-down rises, the hold drop two.
   assert property (POWER_DOWN [*3] |-> !TRACK_HOLD)
      else $error("sample held while powered down");
endmodule // sac_ctrl_properties

/* File: bench/sac_host_model.sv */
`timescale 1ns/10ps

// Serial master: drives select, clock and data, samples the replies.
module sac_host_model (
   input wire logic MCLK,
   input wire logic DOUT,
   input wire logic CONVERSION_STROBE,
   output logic CS_N,
   output logic SCLK,
   output logic DIN
);
   // Clock stands low and select high until a frame is started.
   initial begin
      CS_N = 1'h1;
      SCLK = 1'h0;
      DIN = 1'h0;
   end

   // Select moves only with the clock low, then waits for resync.
   task automatic sel(input logic v);
      CS_N <= v;
      repeat (8) @(posedge MCLK);
   endtask

   // Frames are a few microseconds, far inside the hold limit.
   // Bits go out MSB first; replies are read late in each high phase.
   task automatic xfer(input logic [31:0] tx, input int n,
      output logic [31:0] rx, output logic [31:0] st);
      rx = 32'h0;
      st = 32'h0;
      for (int i = n - 1; i >= 0; i--) begin
         DIN <= tx[i];
         repeat (4) @(posedge MCLK);
         SCLK <= 1'h1;
         repeat (4) @(posedge MCLK);
         rx[i] = DOUT;
         st[i] = CONVERSION_STROBE;
         SCLK <= 1'h0;
      end
      DIN <= ~tx[0]; // Released line shows the inverse of its last bit.
   endtask
endmodule // sac_host_model

/* File: bench/sac_tb.sv */
`timescale 1ns/10ps

// Self-checking bench for the converter control block.
module tb;
   localparam int STEP = 8;
   logic mclk, nrst, slvl, sflt, comp, dout, dout_oe, stb, stb_oe;
   logic th, sgl, uni, pd, ref_en, cs_n, sclk, din;
   logic [7:0] dac, ain;
   logic [2:0] chs;
   logic [31:0] rx, st;
   logic [7:0] ains [4] = '{8'hA5, 8'h3C, 8'h00, 8'hFF};
   logic [7:0] ctrls [4] = '{8'hFF, 8'hF7, 8'h8B, 8'h83};
   logic [1:0] pins [3] = '{2'h0, 2'h1, 2'h2};
   logic [2:0] shutdown_pin_exp [3] = '{3'h4, 3'h2, 3'h0};
   int n_mismatch, num_checks, cnt;

   sac_ctrl #(.INT_STEP_CYC(STEP)) dut (
      .MCLK(mclk), .NRST(nrst), .CS_N(cs_n), .SCLK(sclk), .DIN(din),
      .SHUTDOWN_PIN_LEVEL(slvl), .SHUTDOWN_PIN_FLOAT(sflt),
      .COMP_IN(comp), .DOUT(dout), .DOUT_OE(dout_oe),
      .CONVERSION_STROBE(stb), .CONVERSION_STROBE_OE(stb_oe),
      .DAC_CODE(dac), .TRACK_HOLD(th), .CHAN_SEL(chs),
      .SINGLE_ENDED(sgl), .UNIPOLAR(uni), .POWER_DOWN(pd),
      .REF_ENABLE(ref_en));
   sac_host_model host (.MCLK(mclk), .DOUT(dout),
      .CONVERSION_STROBE(stb), .CS_N(cs_n), .SCLK(sclk), .DIN(din));

   // System clock, 40 ns period.
   initial begin
      mclk = 1'h0;
      forever #20 mclk = ~mclk;
   end

   // Comparator: high while the held input is at or above the trial.
   always @(posedge mclk) begin
      comp <= (ain >= dac);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Compares one result and counts it.
   task check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Bipolar codes are the unipolar code with its top bit inverted.
   function automatic logic [7:0] exp_code(input logic [7:0] a,
      input logic u);
      return u ? a : a ^ 8'h80;
   endfunction

   // Prints the counts and the verdict, then stops.
   task give_verdict();
      $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Three-byte external clock conversion with result and strobe checks.
   task ext_conv(input logic [7:0] c);
      host.xfer({8'h00, c, 16'h0000}, 24, rx, st);
      check("res", {2'h0, exp_code(ain, c[3]), 6'h00}, rx[15:0]);
      check("strobe", 3'h6, st[15:13]);
      check("fields", c[6:2], {chs, uni, sgl});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      nrst = 1'h0;
      slvl = 1'h1;
      sflt = 1'h0;
      comp = 1'h0;
      ain = 8'hA5;
      n_mismatch = 0;
      num_checks = 0;
      repeat (4) @(posedge mclk);
      nrst <= 1'h1;
      repeat (8) @(posedge mclk);
      check("reset", 3'h6, {stb, stb_oe, pd});
      host.sel(1'h0);
      host.xfer(32'h0, 8, rx, st);
      check("idle", 8'h00, rx[7:0]);
      for (int i = 0; i < 4; i++) begin
         ain <= ains[i];
         ext_conv(ctrls[i]);
      end
      host.sel(1'h1);
      check("float", 2'h0, {dout_oe, stb_oe});
      host.sel(1'h0);
      check("drive", 3'h6, {dout_oe, stb_oe, stb});
      // Two conversions ten clocks apart, the second bipolar.
      ain <= 8'h5A;
      host.xfer({4'h0, 8'hFF, 2'h0, 8'hF7, 10'h000}, 28, rx, st);
      check("first", exp_code(8'h5A, 1'h1), rx[17:10]);
      check("second", exp_code(8'h5A, 1'h0), rx[7:0]);
      // Select toggled mid-conversion abandons it.
      host.xfer({20'h0, 8'hFF, 4'h0}, 12, rx, st);
      host.sel(1'h1);
      host.sel(1'h0);
      check("abort", 1'h0, th);
      ain <= 8'h81;
      ext_conv(8'hFF);
      ext_conv(8'hFD);
      check("soft_pd", 1'h1, pd);
      ext_conv(8'hFF);
      check("awake", 1'h0, pd);
      // Internal clock conversion with select raised while it runs.
      ain <= 8'hC3;
      host.xfer({24'h0, 8'hFE}, 8, rx, st);
      host.sel(1'h1);
      check("int_busy", 3'h2, {stb, stb_oe, dout_oe});
      cnt = 0;
      while (stb !== 1'h1 && cnt < 400) begin
         @(posedge mclk);
         cnt++;
      end
      if (cnt == 400) begin
         n_mismatch++;
         give_verdict();
      end
      check("int_len", 1'h1, cnt > 9 * STEP - 16);
      host.sel(1'h0);
      host.xfer(32'h0, 16, rx, st);
      check("int_res", {2'h0, 8'hC3, 6'h00}, rx[15:0]);
      // Shutdown pin states, the low state striking mid-conversion.
      host.xfer({20'h0, 8'hFF, 4'h0}, 12, rx, st);
      for (int i = 0; i < 3; i++) begin
         {slvl, sflt} <= pins[i];
         repeat (8) @(posedge mclk);
         check("shutdown_pin", shutdown_pin_exp[i], {pd, ref_en, th});
      end
      host.sel(1'h1);
      host.sel(1'h0);
      ext_conv(8'hF7);
      give_verdict();
   end
endmodule // tb

// Attach the pin checker to the control block.
bind sac_ctrl sac_ctrl_properties chk (
   .MCLK(MCLK), .NRST(NRST), .CS_N(CS_N), .SCLK(SCLK),
   .SHUTDOWN_PIN_LEVEL(SHUTDOWN_PIN_LEVEL),
   .SHUTDOWN_PIN_FLOAT(SHUTDOWN_PIN_FLOAT), .DOUT(DOUT),
   .DOUT_OE(DOUT_OE), .CONVERSION_STROBE(CONVERSION_STROBE),
   .CONVERSION_STROBE_OE(CONVERSION_STROBE_OE), .TRACK_HOLD(TRACK_HOLD),
   .POWER_DOWN(POWER_DOWN), .REF_ENABLE(REF_ENABLE));
